/* rtl/glue_control_perf_timer.sv */
// glue register bank: resume reset, signal monitor, microsecond counter
`include "glue_regs.svh"
`default_nettype none
module glue_control_perf_timer (
  input wire logic clk,                      // 100 mhz clock
  input wire logic rst_n,                    // standby power-on reset
  input wire logic system_reset_n,           // system reset, async pin
  input wire logic standby_rail,             // standby rail good, pin
  input wire logic power_button_in_n,        // deglitched button, pin
  input wire logic internal_supply_on_state, // 1: internal supply-on drive
  input wire logic ec_halted,                // processor halted
  input wire logic [11:0] bus_addr,          // register byte address
  input wire logic bus_wr_en,                // write strobe
  input wire logic [3:0] bus_be,             // write byte enables
  input wire logic [31:0] bus_wdata,         // write data
  input wire logic bus_rd_en,                // read strobe
  output logic [31:0] bus_rdata,             // read data, registered
  output logic bus_rvalid,                   // read data valid pulse
  output logic resume_reset_out_n            // resume reset pin
);

  glue_pkg::glue_state_type st_reg;
  glue_pkg::glue_state_type st_next;

  // the divider sits in its own module so the bank stays pure decode
  tick_if tk ();

  usec_tick_gen tick_gen (
    .clk(clk),
    .rst_n(rst_n),
    .tk(tk.source)
  );

  // address match for a word-aligned register
  function automatic logic hit(input glue_pkg::bus_addr_type a,
                               input glue_pkg::bus_addr_type off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  // read mux; reserved bits and unmapped words read as zero
  function automatic logic [31:0] read_word(
      input glue_pkg::bus_addr_type a,
      input glue_pkg::glue_state_type s,
      input logic supply_on);
    read_word = 32'h0000_0000;
    if (hit(a, `GLUE_OFF_RESUME)) begin
      read_word[`GLUE_RESUME_BIT] = s.resume_bit;
    end else if (hit(a, `GLUE_OFF_MONITOR)) begin
      read_word[`GLUE_MON_BUTTON_BIT] = s.button_sync;
      read_word[`GLUE_MON_SUPPLY_BIT] = !supply_on;
    end else if (hit(a, `GLUE_OFF_COUNTER)) begin
      read_word = s.count;
    end else if (hit(a, `GLUE_OFF_CONTROL)) begin
      read_word[`GLUE_CTL_ENABLE_BIT] = s.ctl_enable;
      read_word[`GLUE_CTL_NO_HALT_BIT] = s.ctl_no_halt;
    end
  endfunction : read_word

  // write decode; 8-bit registers need byte lane 0
  logic wr_resume;
  logic wr_control;
  logic wr_monitor;
  logic load_count;
  logic count_run;
  logic count_inc;
  logic [31:0] count_plus;

  assign wr_resume = bus_wr_en && bus_be[0]
                     && hit(bus_addr, `GLUE_OFF_RESUME);
  assign wr_control = bus_wr_en && bus_be[0]
                      && hit(bus_addr, `GLUE_OFF_CONTROL);
  assign wr_monitor = bus_wr_en && hit(bus_addr, `GLUE_OFF_MONITOR);
  // partial stores to the counter are dropped: a torn load is worse
  assign load_count = bus_wr_en && (bus_be == 4'hf)
                      && hit(bus_addr, `GLUE_OFF_COUNTER);
  // counting permitted only when enabled and, if gated, not halted
  assign count_run = st_reg.ctl_enable
                     && !(st_reg.ctl_no_halt && ec_halted);
  assign count_inc = tk.tick && count_run;
  assign count_plus = st_reg.count + 32'h0000_0001;

  // next state of the whole bank
  always_comb begin
    st_next = st_reg;
    // fields hold unless a branch below changes them
    // pin synchronisers; first stage read only by the second
    st_next.sysrst_meta = system_reset_n;
    st_next.sysrst_sync = st_reg.sysrst_meta;
    st_next.button_meta = power_button_in_n;
    st_next.button_sync = st_reg.button_meta;
    st_next.rail_meta = standby_rail;
    st_next.rail_sync = st_reg.rail_meta;

    // resume reset control bit; only bit 0 is stored
    if (wr_resume) begin
      st_next.resume_bit = bus_wdata[`GLUE_RESUME_BIT];
    end
    // a missing standby rail overrides software
    if (!st_reg.rail_sync) begin
      st_next.resume_bit = 1'b0;
    end

    // counter control; upper bits are not stored
    if (wr_control) begin
      st_next.ctl_enable = bus_wdata[`GLUE_CTL_ENABLE_BIT];
      st_next.ctl_no_halt = bus_wdata[`GLUE_CTL_NO_HALT_BIT];
    end

    // counter: system reset, then load, then increment
    if (!st_reg.sysrst_sync) begin
      st_next.count = `GLUE_COUNTER_RESET;
    end else if (load_count) begin
      st_next.count = bus_wdata;
    end else if (count_inc) begin
      st_next.count = count_plus;
    end

    // read path answers one cycle after the strobe
    st_next.rvalid = bus_rd_en;
    if (bus_rd_en) begin
      st_next.rdata = read_word(bus_addr, st_reg,
                                internal_supply_on_state);
    end
  end

  // async reset models standby power-on; constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.resume_bit <= `GLUE_RESUME_RESET;
      st_reg.ctl_enable <= `GLUE_ENABLE_RESET;
      st_reg.ctl_no_halt <= `GLUE_NO_HALT_RESET;
      st_reg.count <= `GLUE_COUNTER_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // pin and read port come straight from flip-flops, glitch free
  assign resume_reset_out_n = st_reg.resume_bit;
  assign bus_rdata = st_reg.rdata;
  assign bus_rvalid = st_reg.rvalid;

  // checks on the resume reset pin
  a_resume_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_resume && bus_wdata[0] && st_reg.rail_sync)
      |=> resume_reset_out_n)
  else $error("resume reset not released by write of one");

  a_resume_assert: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_resume && !bus_wdata[0]) |=> !resume_reset_out_n)
  else $error("resume reset not asserted by write of zero");

  a_rail_loss: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st_reg.rail_sync |=> !resume_reset_out_n)
  else $error("resume reset released without standby rail");

  a_rail_pin_path: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!standby_rail [*3]) |-> ##1 !resume_reset_out_n)
  else $error("rail loss did not reach resume reset within bound");

  // checks on the monitor read
  a_monitor_button: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_rd_en && hit(bus_addr, `GLUE_OFF_MONITOR))
      |=> bus_rvalid && (bus_rdata[0] == $past(st_reg.button_sync)))
  else $error("monitor bit 0 does not follow button");

  a_monitor_supply: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_rd_en && hit(bus_addr, `GLUE_OFF_MONITOR))
      |=> (bus_rdata[1] == !$past(internal_supply_on_state))
          && (bus_rdata[31:2] == 30'h0))
  else $error("monitor bit 1 not inverted supply-on");

  // checks on the counter
  a_count_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    (count_inc && !load_count && st_reg.sysrst_sync)
      |=> st_reg.count == $past(count_plus))
  else $error("counter did not step on tick");

  a_count_wrap: assert property (
    @(posedge clk) disable iff (!rst_n)
    (count_inc && !load_count && st_reg.sysrst_sync
     && (st_reg.count == 32'hffff_ffff))
      |=> st_reg.count == 32'h0000_0000)
  else $error("counter did not wrap to zero");

  a_count_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (load_count && st_reg.sysrst_sync)
      |=> st_reg.count == $past(bus_wdata))
  else $error("full store did not load counter");

  a_count_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st_reg.ctl_enable && !load_count && st_reg.sysrst_sync)
      |=> $stable(st_reg.count))
  else $error("counter moved while disabled");

  a_halt_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_reg.ctl_no_halt && ec_halted && !load_count
     && st_reg.sysrst_sync) |=> $stable(st_reg.count))
  else $error("counter moved while processor halted");

  a_halt_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_reg.ctl_enable && !st_reg.ctl_no_halt && tk.tick
     && !load_count && st_reg.sysrst_sync)
      |=> st_reg.count != $past(st_reg.count))
  else $error("counter stalled with halt gating off");

  // checks on control and ignored writes
  a_control_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_rd_en && hit(bus_addr, `GLUE_OFF_CONTROL))
      |=> (bus_rdata[31:2] == 30'h0)
          && (bus_rdata[1:0] == $past({st_reg.ctl_no_halt,
                                       st_reg.ctl_enable})))
  else $error("control read shows reserved bits");

  a_monitor_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_monitor && st_reg.rail_sync)
      |=> $stable(st_reg.resume_bit) && $stable(st_reg.ctl_enable)
          && $stable(st_reg.ctl_no_halt))
  else $error("monitor write changed a register");

  a_partial_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_wr_en && hit(bus_addr, `GLUE_OFF_COUNTER)
     && (bus_be != 4'hf) && !count_inc && st_reg.sysrst_sync)
      |=> $stable(st_reg.count))
  else $error("partial store altered counter");

  // checks on read words, control writes and held state
  a_counter_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_rd_en && hit(bus_addr, `GLUE_OFF_COUNTER))
      |=> (bus_rdata == $past(st_reg.count)))
  else $error("counter read does not show the count");

  a_resume_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_rd_en && hit(bus_addr, `GLUE_OFF_RESUME))
      |=> (bus_rdata == {31'h0, $past(st_reg.resume_bit)}))
  else $error("resume read shows wrong bit or reserved bits");

  a_resume_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!wr_resume && st_reg.rail_sync) |=> $stable(resume_reset_out_n))
  else $error("resume reset pin moved without a write");

  a_rail_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!resume_reset_out_n && !wr_resume) |=> !resume_reset_out_n)
  else $error("resume reset released without a write");

  a_control_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_control |=> ({st_reg.ctl_no_halt, st_reg.ctl_enable}
                    == $past(bus_wdata[1:0])))
  else $error("control write did not land");

  a_control_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_control
      |=> $stable(st_reg.ctl_enable) && $stable(st_reg.ctl_no_halt))
  else $error("control bits moved without a write");

  // checks on the counter against system reset and the tick
  a_count_sysrst: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st_reg.sysrst_sync |=> (st_reg.count == `GLUE_COUNTER_RESET))
  else $error("counter not cleared during system reset");

  a_count_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!tk.tick && !load_count && st_reg.sysrst_sync)
      |=> $stable(st_reg.count))
  else $error("counter moved without a tick");

endmodule : glue_control_perf_timer
`default_nettype wire

/* rtl/glue_pkg.sv */
// types shared by the glue register bank and its tick generator
`default_nettype none
package glue_pkg;

  typedef logic [11:0] bus_addr_type;

  // whole state of the register bank
  typedef struct packed {
    logic resume_bit;
    logic ctl_enable;
    logic ctl_no_halt;
    logic [31:0] count;
    logic [31:0] rdata;
    logic rvalid;
    logic sysrst_meta;
    logic sysrst_sync;
    logic button_meta;
    logic button_sync;
    logic rail_meta;
    logic rail_sync;
  } glue_state_type;

  // whole state of the microsecond tick generator
  typedef struct packed {
    logic [6:0] div;
    logic tick;
  } tick_state_type;

endpackage : glue_pkg
`default_nettype wire

/* rtl/glue_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef GLUE_REGS_SVH
`define GLUE_REGS_SVH

// byte offsets on the peripheral bus
`define GLUE_OFF_RESUME 12'h180
`define GLUE_OFF_MONITOR 12'h184
`define GLUE_OFF_COUNTER 12'h188
`define GLUE_OFF_CONTROL 12'h18c

// field positions
`define GLUE_RESUME_BIT 0
`define GLUE_MON_BUTTON_BIT 0
`define GLUE_MON_SUPPLY_BIT 1
`define GLUE_CTL_ENABLE_BIT 0
`define GLUE_CTL_NO_HALT_BIT 1

// reset values
`define GLUE_RESUME_RESET 1'b0
`define GLUE_ENABLE_RESET 1'b0
`define GLUE_NO_HALT_RESET 1'b0
`define GLUE_COUNTER_RESET 32'h0000_0000

// timing: one microsecond tick from the 10 ns clock
`define GLUE_CLK_PERIOD_NS 10
`define GLUE_TICK_PERIOD_NS 1000
`define GLUE_TICK_CYCLES (`GLUE_TICK_PERIOD_NS / `GLUE_CLK_PERIOD_NS)

`endif

/* rtl/tick_if.sv */
// one-cycle microsecond strobe between the tick generator and the bank
`default_nettype none
interface tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface : tick_if
`default_nettype wire

/* rtl/usec_tick_gen.sv */
// divides the 100 MHz clock into a one-cycle 1 MHz tick
`include "glue_regs.svh"
`default_nettype none
module usec_tick_gen (
  input wire logic clk,   // 100 mhz clock
  input wire logic rst_n, // async reset, active low
  tick_if.source tk       // tick strobe out
);
  localparam logic [6:0] DIV_LAST = 7'(`GLUE_TICK_CYCLES - 1);

  glue_pkg::tick_state_type st_reg;
  glue_pkg::tick_state_type st_next;

  // free-running divider; tick is registered so it is glitch free
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.div == DIV_LAST) begin
      st_next.div = 7'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;

  a_tick_spacing: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_reg.tick |=> !st_reg.tick [*8])
  else $error("tick repeated too soon");

endmodule : usec_tick_gen
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the glue register bank and microsecond counter
`include "glue_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, system_reset_n, standby_rail, power_button_in_n;
  logic internal_supply_on_state, ec_halted, bus_wr_en, bus_rd_en;
  logic [11:0] bus_addr;
  logic [3:0] bus_be;
  logic [31:0] bus_wdata, bus_rdata, rv;
  logic bus_rvalid, resume_reset_out_n;
  int bad_count, tests_run;

  glue_control_perf_timer u_dut (.clk(clk), .rst_n(rst_n),
    .system_reset_n(system_reset_n), .standby_rail(standby_rail),
    .power_button_in_n(power_button_in_n),
    .internal_supply_on_state(internal_supply_on_state),
    .ec_halted(ec_halted), .bus_addr(bus_addr), .bus_wr_en(bus_wr_en),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rd_en(bus_rd_en),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .resume_reset_out_n(resume_reset_out_n));

  // free-running 100 mhz clock
  always #5 clk = ~clk;

  task automatic print_verdict;
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // range compare: tick phase against the bus access is not fixed
  task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
    logic ok;
    ok = (g >= lo) && (g <= hi);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // write strobe held for exactly one sampling edge
  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_be <= be;
    bus_wdata <= d;
    bus_wr_en <= 1'b1;
    @(posedge clk);
    bus_wr_en <= 1'b0;
    #1;
  endtask : wr

  // read: data is taken with the valid pulse, bounded wait
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int i;
    @(posedge clk);
    bus_addr <= a;
    bus_rd_en <= 1'b1;
    @(posedge clk);
    bus_rd_en <= 1'b0;
    for (i = 0; i < 3; i++) begin
      #1;
      if (bus_rvalid === 1'b1) break;
      @(posedge clk);
    end
    if (i == 3) begin
      bad_count++;
      $display("MISMATCH bus_rvalid expected 1 seen 0");
      print_verdict();
    end
    d = bus_rdata;
  endtask : rd

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    rd(a, rv);
    chk(nm, e, rv);
  endtask : rchk

  task automatic t_reset;
    chk("resume pin at power-up", 32'h0, {31'h0, resume_reset_out_n});
    rchk("resume reg", `GLUE_OFF_RESUME, 32'h0);
    rchk("counter reg", `GLUE_OFF_COUNTER, 32'h0);
    rchk("control reg", `GLUE_OFF_CONTROL, 32'h0);
    rchk("unmapped read", 12'h1fc, 32'h0);
  endtask : t_reset

  task automatic t_resume;
    wr(`GLUE_OFF_RESUME, 4'h1, 32'hffff_ffff);
    chk("resume pin set", 32'h1, {31'h0, resume_reset_out_n});
    rchk("resume reserved", `GLUE_OFF_RESUME, 32'h1);
    wr(`GLUE_OFF_RESUME, 4'h1, 32'h0000_00fe);
    chk("resume pin clear", 32'h0, {31'h0, resume_reset_out_n});
    wr(`GLUE_OFF_RESUME, 4'h0, 32'h1);
    chk("resume no byte", 32'h0, {31'h0, resume_reset_out_n});
    wr(`GLUE_OFF_RESUME, 4'h1, 32'h1);
    @(posedge clk);
    standby_rail <= 1'b0;
    cyc(4);
    chk("resume pin rail low", 32'h0, {31'h0, resume_reset_out_n});
    @(posedge clk);
    standby_rail <= 1'b1;
    cyc(5);
    chk("resume after rail", 32'h0, {31'h0, resume_reset_out_n});
  endtask : t_resume

  // all four combinations of button and supply-on drive
  task automatic t_monitor;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      power_button_in_n <= i[0];
      internal_supply_on_state <= i[1];
      cyc(4);
      wr(`GLUE_OFF_MONITOR, 4'hf, 32'hffff_ffff);
      rchk("monitor", `GLUE_OFF_MONITOR, {30'h0, !i[1], i[0]});
    end
  endtask : t_monitor

  task automatic t_control;
    wr(`GLUE_OFF_CONTROL, 4'hf, 32'hffff_ffff);
    rchk("control reserved", `GLUE_OFF_CONTROL, 32'h3);
    wr(`GLUE_OFF_CONTROL, 4'he, 32'h0);
    rchk("control no byte", `GLUE_OFF_CONTROL, 32'h3);
  endtask : t_control

  // enable and halt-gating table: counts over 300 clocks
  task automatic t_gate;
    logic [31:0] ctl [4] = '{32'h0, 32'h3, 32'h1, 32'h3};
    logic hlt [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] lo [4] = '{32'h50, 32'h50, 32'h53, 32'h53};
    logic [31:0] hi [4] = '{32'h50, 32'h50, 32'h54, 32'h54};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ec_halted <= hlt[i];
      wr(`GLUE_OFF_CONTROL, 4'h1, ctl[i]);
      wr(`GLUE_OFF_COUNTER, 4'hf, 32'h50);
      cyc(300);
      rd(`GLUE_OFF_COUNTER, rv);
      chk_rng("gated count", lo[i], hi[i], rv);
    end
    @(posedge clk);
    ec_halted <= 1'b0;
  endtask : t_gate

  task automatic t_rate_wrap;
    wr(`GLUE_OFF_CONTROL, 4'h1, 32'h1);
    wr(`GLUE_OFF_COUNTER, 4'hf, 32'd100);
    cyc(10 * `GLUE_TICK_CYCLES);
    rd(`GLUE_OFF_COUNTER, rv);
    chk_rng("count rate", 32'd110, 32'd111, rv);
    wr(`GLUE_OFF_COUNTER, 4'hf, 32'hffff_ffff);
    cyc(150);
    rd(`GLUE_OFF_COUNTER, rv);
    chk_rng("count wrap", 32'h0, 32'h1, rv);
  endtask : t_rate_wrap

  // a partial store must not disturb a held count
  task automatic t_partial;
    wr(`GLUE_OFF_CONTROL, 4'h1, 32'h0);
    wr(`GLUE_OFF_COUNTER, 4'hf, 32'h1122_3344);
    wr(`GLUE_OFF_COUNTER, 4'h7, 32'h0);
    rchk("partial store", `GLUE_OFF_COUNTER, 32'h1122_3344);
  endtask : t_partial

  task automatic t_sysrst;
    wr(`GLUE_OFF_CONTROL, 4'h1, 32'h1);
    wr(`GLUE_OFF_COUNTER, 4'hf, 32'h1234);
    @(posedge clk);
    system_reset_n <= 1'b0;
    cyc(5);
    wr(`GLUE_OFF_COUNTER, 4'hf, 32'h77);
    rchk("count in sys reset", `GLUE_OFF_COUNTER, 32'h0);
    @(posedge clk);
    system_reset_n <= 1'b1;
    cyc(4);
    rchk("control kept", `GLUE_OFF_CONTROL, 32'h1);
  endtask : t_sysrst

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    system_reset_n = 1'b1;
    standby_rail = 1'b1;
    power_button_in_n = 1'b1;
    internal_supply_on_state = 1'b0;
    ec_halted = 1'b0;
    bus_addr = 12'h000;
    bus_wr_en = 1'b0;
    bus_rd_en = 1'b0;
    bus_be = 4'h0;
    bus_wdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(6);
    t_reset();
    t_resume();
    t_monitor();
    t_control();
    t_gate();
    t_rate_wrap();
    t_partial();
    t_sysrst();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
